// ===== rtl/ucd_top.sv
// Command decoder for upper-nibble codes 4..B of one UART channel
// What this block does
// - Command write: upper nibble is a command code, lower nibble is ignored.
// - Code 0100 clears break, parity, framing and overrun status flags.
// - Block mode: error flags stay set until the error-reset command.
// - Character mode: parity, framing, break follow the head character.
// - Overrun always latches, cleared only by the error-reset command.
// - Code 0101 clears the break-change status flag.
// - Code 0110 drives the serial output low until stop-break.
// - Idle transmitter: break begins within two bit periods.
// - Busy transmitter: break waits until transmitter-empty is true.
// - Code 0111 returns serial output high within two bit periods.
// - After break, output stays high one bit before the next character.
// - Code 1000 sets receiver rate-generator extend bit.
// - Code 1001 clears receiver rate-generator extend bit.
// - Code 1010 sets transmitter rate-generator extend bit.
// - Code 1011 clears transmitter rate-generator extend bit.
module ucd_top
    import ucd_pkg::*;
#(
    parameter int BIT_CYC = UCD_BIT_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Receiver and transmitter core, same clock
    input wire logic rx_head_par_i,
    input wire logic rx_head_frm_i,
    input wire logic rx_head_brk_i,
    input wire logic rx_err_par_i,
    input wire logic rx_err_frm_i,
    input wire logic rx_err_brk_i,
    input wire logic rx_overrun_i,
    input wire logic brk_change_i,
    input wire logic tx_empty_flag_i,
    input wire logic tx_char_start_i,
    input wire logic tx_core_data_i,
    // Channel outputs
    output logic serial_tx_out_o,
    output logic tx_hold_o,
    output logic rx_ext_o,
    output logic tx_ext_o,
    output logic irq_o
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic par;
        logic frm;
        logic brk;
        logic ovr;
        logic brk_chg;
        logic rx_ext;
        logic tx_ext;
        logic block_mode;
        logic tx_en;
        ucd_tx_state_t tx_st;
        logic [UCD_BIT_CNT_W-1:0] bit_cnt;
        logic txd;
        logic hold;
        logic [UCD_IRQ_W-1:0] irq_stat;
        logic [UCD_IRQ_W-1:0] irq_mask;
        logic irq;
    } ucd_state_t;

    localparam logic [UCD_BIT_CNT_W-1:0] BIT_LAST =
        UCD_BIT_CNT_W'(BIT_CYC - 1);

    ucd_state_t s_q, s_d;

    logic wr_acc, rd_acc, cmd_wr;
    logic [3:0] code;
    logic [31:0] stat_word;
    logic [UCD_IRQ_W-1:0] irq_ev;

    assign wr_acc = psel_i && penable_i && pwrite_i && !s_q.pready;
    assign rd_acc = psel_i && penable_i && !pwrite_i && !s_q.pready;
    // One strobe per completed access cycle
    assign cmd_wr = wr_acc && (paddr_i == UCD_CMD_OFF);
    assign code = pwdata_i[UCD_CMD_CODE_LSB +: 4];

    always_comb begin
        stat_word = 32'h0;
        stat_word[UCD_ST_OVR_BIT] = s_q.ovr;
        stat_word[UCD_ST_PAR_BIT] = s_q.par;
        stat_word[UCD_ST_FRM_BIT] = s_q.frm;
        stat_word[UCD_ST_BRK_BIT] = s_q.brk;
        stat_word[UCD_ST_RXEXT_BIT] = s_q.rx_ext;
        stat_word[UCD_ST_TXEXT_BIT] = s_q.tx_ext;
        stat_word[UCD_ST_BREAK_BIT] = (s_q.tx_st == UCD_TX_BREAK);
        stat_word[UCD_ST_BRKCHG_BIT] = s_q.brk_chg;
    end

    always_comb begin
        s_d = s_q;
        irq_ev = '0;
        // APB answers in the cycle after the access phase starts
        s_d.pready = psel_i && penable_i && !s_q.pready;
        s_d.pslverr = 1'b0;
        if (rd_acc) begin
            unique case (paddr_i)
                UCD_STAT_OFF: s_d.prdata = stat_word;
                UCD_CTRL_OFF: s_d.prdata = {30'h0, s_q.tx_en, s_q.block_mode};
                UCD_IRQ_STAT_OFF: s_d.prdata = {29'h0, s_q.irq_stat};
                UCD_IRQ_MASK_OFF: s_d.prdata = {29'h0, s_q.irq_mask};
                UCD_CMD_OFF: s_d.prdata = 32'h0;
                default: begin
                    s_d.prdata = 32'h0;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end else if (wr_acc) begin
            unique case (paddr_i)
                UCD_CMD_OFF: ;
                UCD_CTRL_OFF: begin
                    s_d.block_mode = pwdata_i[UCD_CTRL_BLOCK_MODE_BIT];
                    s_d.tx_en = pwdata_i[UCD_CTRL_TX_EN_BIT];
                end
                UCD_IRQ_MASK_OFF: s_d.irq_mask = pwdata_i[UCD_IRQ_W-1:0];
                UCD_IRQ_STAT_OFF: ;
                UCD_STAT_OFF: ;
                default: s_d.pslverr = 1'b1;
            endcase
        end
        // Error flags; error reset first so a new error still wins
        if (cmd_wr && code == UCD_CMD_RST_ERR) begin
            s_d.par = 1'b0;
            s_d.frm = 1'b0;
            s_d.brk = 1'b0;
            s_d.ovr = 1'b0;
        end
        if (s_q.block_mode) begin
            if (rx_err_par_i) s_d.par = 1'b1;
            if (rx_err_frm_i) s_d.frm = 1'b1;
            if (rx_err_brk_i) s_d.brk = 1'b1;
        end else begin
            s_d.par = rx_head_par_i;
            s_d.frm = rx_head_frm_i;
            s_d.brk = rx_head_brk_i;
        end
        if (rx_overrun_i) s_d.ovr = 1'b1;
        if (cmd_wr && code == UCD_CMD_RST_BRK_CHG) s_d.brk_chg = 1'b0;
        if (brk_change_i) s_d.brk_chg = 1'b1;
        if (cmd_wr) begin
            unique case (code)
                UCD_CMD_SET_RX_EXT: s_d.rx_ext = 1'b1;
                UCD_CMD_CLR_RX_EXT: s_d.rx_ext = 1'b0;
                UCD_CMD_SET_TX_EXT: s_d.tx_ext = 1'b1;
                UCD_CMD_CLR_TX_EXT: s_d.tx_ext = 1'b0;
                default: ;
            endcase
        end
        // Break sequencer
        if (s_q.bit_cnt != '0) s_d.bit_cnt = s_q.bit_cnt - 1'b1;
        unique case (s_q.tx_st)
            UCD_TX_IDLE: begin
                s_d.txd = tx_core_data_i;
                s_d.hold = 1'b0;
                // Ignored while the transmitter is disabled
                if (cmd_wr && code == UCD_CMD_START_BRK && s_q.tx_en) begin
                    s_d.tx_st = UCD_TX_WAIT;
                    s_d.hold = 1'b1;
                end
            end
            UCD_TX_WAIT: begin
                s_d.txd = tx_core_data_i;
                // Idle line starts the break on the next edge
                if (tx_empty_flag_i) begin
                    s_d.tx_st = UCD_TX_BREAK;
                    s_d.txd = 1'b0;
                end
                if (cmd_wr && code == UCD_CMD_STOP_BRK) begin
                    s_d.tx_st = UCD_TX_IDLE;
                    s_d.hold = 1'b0;
                    s_d.txd = tx_core_data_i;
                end
            end
            UCD_TX_BREAK: begin
                s_d.txd = 1'b0;
                if (cmd_wr && code == UCD_CMD_STOP_BRK) begin
                    s_d.tx_st = UCD_TX_MARK;
                    s_d.txd = 1'b1;
                    s_d.bit_cnt = BIT_LAST;
                    irq_ev[UCD_IRQ_BRKDONE_BIT] = 1'b1;
                end
            end
            UCD_TX_MARK: begin
                s_d.txd = 1'b1;
                if (s_q.bit_cnt == '0) begin
                    s_d.tx_st = UCD_TX_IDLE;
                    s_d.hold = 1'b0;
                end
            end
        endcase
        // Interrupts: set wins over write-one-to-clear
        irq_ev[UCD_IRQ_ERR_BIT] = rx_err_par_i || rx_err_frm_i
            || rx_err_brk_i || rx_overrun_i;
        irq_ev[UCD_IRQ_BRKCHG_BIT] = brk_change_i;
        if (wr_acc && paddr_i == UCD_IRQ_STAT_OFF)
            s_d.irq_stat = s_q.irq_stat & ~pwdata_i[UCD_IRQ_W-1:0];
        s_d.irq_stat = s_d.irq_stat | irq_ev;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.txd <= 1'b1;
            s_q.tx_st <= UCD_TX_IDLE;
            s_q.irq_mask <= UCD_MASK_RST;
            {s_q.tx_en, s_q.block_mode} <= UCD_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign serial_tx_out_o = s_q.txd;
    assign tx_hold_o = s_q.hold;
    assign rx_ext_o = s_q.rx_ext;
    assign tx_ext_o = s_q.tx_ext;
    assign irq_o = s_q.irq;

    // Assertions
    property p_rx_ext_set;
        @(posedge core_clk_i) disable iff (reset_i)
        cmd_wr && code == UCD_CMD_SET_RX_EXT |=> rx_ext_o;
    endproperty
    a_rx_ext_set: assert property (p_rx_ext_set)
        else $error("rx extend not set");
    property p_rx_ext_clr;
        @(posedge core_clk_i) disable iff (reset_i)
        cmd_wr && code == UCD_CMD_CLR_RX_EXT |=> !rx_ext_o;
    endproperty
    a_rx_ext_clr: assert property (p_rx_ext_clr)
        else $error("rx extend not cleared");
    property p_tx_ext_set;
        @(posedge core_clk_i) disable iff (reset_i)
        cmd_wr && code == UCD_CMD_SET_TX_EXT |=> tx_ext_o;
    endproperty
    a_tx_ext_set: assert property (p_tx_ext_set)
        else $error("tx extend not set");
    property p_tx_ext_clr;
        @(posedge core_clk_i) disable iff (reset_i)
        cmd_wr && code == UCD_CMD_CLR_TX_EXT |=> !tx_ext_o;
    endproperty
    a_tx_ext_clr: assert property (p_tx_ext_clr)
        else $error("tx extend not cleared");
    property p_err_rst;
        @(posedge core_clk_i) disable iff (reset_i)
        cmd_wr && code == UCD_CMD_RST_ERR && !rx_overrun_i |=> !s_q.ovr;
    endproperty
    a_err_rst: assert property (p_err_rst)
        else $error("overrun not cleared by error reset");
    property p_ovr_sticky;
        @(posedge core_clk_i) disable iff (reset_i)
        s_q.ovr && !(cmd_wr && code == UCD_CMD_RST_ERR) |=> s_q.ovr;
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky)
        else $error("overrun dropped without reset command");
    property p_brkchg_clr;
        @(posedge core_clk_i) disable iff (reset_i)
        cmd_wr && code == UCD_CMD_RST_BRK_CHG && !brk_change_i
        |=> !s_q.brk_chg;
    endproperty
    a_brkchg_clr: assert property (p_brkchg_clr)
        else $error("break change flag not cleared");
    sequence s_stop_in_break;
        s_q.tx_st == UCD_TX_BREAK && cmd_wr && code == UCD_CMD_STOP_BRK;
    endsequence
    property p_stop_high;
        @(posedge core_clk_i) disable iff (reset_i)
        s_stop_in_break |=> serial_tx_out_o [*2];
    endproperty
    a_stop_high: assert property (p_stop_high)
        else $error("line not high after stop break");
    property p_break_low;
        @(posedge core_clk_i) disable iff (reset_i)
        s_q.tx_st == UCD_TX_BREAK |-> !serial_tx_out_o;
    endproperty
    a_break_low: assert property (p_break_low)
        else $error("line not low during break");
    property p_wait_empty;
        @(posedge core_clk_i) disable iff (reset_i)
        s_q.tx_st == UCD_TX_WAIT && !tx_empty_flag_i
        |=> s_q.tx_st != UCD_TX_BREAK;
    endproperty
    a_wait_empty: assert property (p_wait_empty)
        else $error("break began before transmitter empty");
    property p_no_brk_disabled;
        @(posedge core_clk_i) disable iff (reset_i)
        s_q.tx_st == UCD_TX_IDLE && !s_q.tx_en |=> s_q.tx_st == UCD_TX_IDLE;
    endproperty
    a_no_brk_disabled: assert property (p_no_brk_disabled)
        else $error("break started with transmitter disabled");
endmodule

// ===== rtl/ucd_pkg.sv
// Package for the UART channel command decoder
package ucd_pkg;
    // APB register byte offsets
    localparam logic [7:0] UCD_CMD_OFF = 8'h00;
    localparam logic [7:0] UCD_STAT_OFF = 8'h04;
    localparam logic [7:0] UCD_CTRL_OFF = 8'h08;
    localparam logic [7:0] UCD_IRQ_STAT_OFF = 8'h0C;
    localparam logic [7:0] UCD_IRQ_MASK_OFF = 8'h10;
    // Command codes, upper nibble of the command write
    localparam logic [3:0] UCD_CMD_RST_ERR = 4'h4;
    localparam logic [3:0] UCD_CMD_RST_BRK_CHG = 4'h5;
    localparam logic [3:0] UCD_CMD_START_BRK = 4'h6;
    localparam logic [3:0] UCD_CMD_STOP_BRK = 4'h7;
    localparam logic [3:0] UCD_CMD_SET_RX_EXT = 4'h8;
    localparam logic [3:0] UCD_CMD_CLR_RX_EXT = 4'h9;
    localparam logic [3:0] UCD_CMD_SET_TX_EXT = 4'hA;
    localparam logic [3:0] UCD_CMD_CLR_TX_EXT = 4'hB;
    // Field positions
    localparam int UCD_CMD_CODE_LSB = 4;
    localparam int UCD_CTRL_BLOCK_MODE_BIT = 0;
    localparam int UCD_CTRL_TX_EN_BIT = 1;
    // Status word bit positions (upper status bits of the channel)
    localparam int UCD_ST_OVR_BIT = 4;
    localparam int UCD_ST_PAR_BIT = 5;
    localparam int UCD_ST_FRM_BIT = 6;
    localparam int UCD_ST_BRK_BIT = 7;
    localparam int UCD_ST_RXEXT_BIT = 8;
    localparam int UCD_ST_TXEXT_BIT = 9;
    localparam int UCD_ST_BREAK_BIT = 10;
    localparam int UCD_ST_BRKCHG_BIT = 11;
    // Interrupt status bits
    localparam int UCD_IRQ_ERR_BIT = 0;
    localparam int UCD_IRQ_BRKCHG_BIT = 1;
    localparam int UCD_IRQ_BRKDONE_BIT = 2;
    localparam int UCD_IRQ_W = 3;
    // Reset values
    localparam logic [1:0] UCD_CTRL_RST = 2'h0;
    localparam logic [2:0] UCD_MASK_RST = 3'h0;
    // Timing: bit time derived from bit rate and clock rate
    localparam int UCD_CLK_HZ = 40_000_000;
    localparam int UCD_BIT_RATE = 9600;
    localparam int UCD_BIT_CYC = UCD_CLK_HZ / UCD_BIT_RATE;
    localparam int UCD_BIT_CNT_W = 16;
    typedef enum logic [1:0] {
        UCD_TX_IDLE,
        UCD_TX_WAIT,
        UCD_TX_BREAK,
        UCD_TX_MARK
    } ucd_tx_state_t;
endpackage

// ===== tb/ucd_host.sv
// Host processor model: APB master of the command decoder
module ucd_host (
    // Clock
    input wire logic clk_i,
    // APB master side
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end
    // Leading edge wait keeps release and next setup on separate edges
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= wd;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule

// ===== tb/ucd_top_tb.sv
// Self-checking testbench of the channel command decoder
module ucd_top_tb import ucd_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 8;
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [2:0] head;
    logic [4:0] ev;
    logic tx_empty, tx_data, serial, hold, rx_ext, tx_ext, irq, e;
    int failures, checked, n;
    ucd_top #(.BIT_CYC(BC)) u_ucd_top (.core_clk_i(clk), .reset_i(rst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rx_head_par_i(head[0]),
        .rx_head_frm_i(head[1]), .rx_head_brk_i(head[2]),
        .rx_err_par_i(ev[0]), .rx_err_frm_i(ev[1]), .rx_err_brk_i(ev[2]),
        .rx_overrun_i(ev[3]), .brk_change_i(ev[4]),
        .tx_empty_flag_i(tx_empty), .tx_char_start_i(1'b0),
        .tx_core_data_i(tx_data), .serial_tx_out_o(serial),
        .tx_hold_o(hold), .rx_ext_o(rx_ext), .tx_ext_o(tx_ext), .irq_o(irq));
    ucd_host u_ucd_host (.clk_i(clk), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
        .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_ucd_host.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a);
        u_ucd_host.xfer(1'b0, a, 32'h0, r, e);
    endtask
    task automatic cmd(input logic [3:0] c);
        wr(UCD_CMD_OFF, {24'h0, c, 4'h0});
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic wait_tx(input logic v);
        n = 0;
        while (serial !== v && n < 2 * BC) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic t_reset();
        rd(UCD_STAT_OFF);
        chk(r & 32'hFF0, 32'h0);
        chk({28'h0, serial, hold, tx_ext, irq}, 32'h8);
        u_ucd_host.xfer(1'b0, 8'h40, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
    endtask
    task automatic t_ext();
        logic [3:0] c [4];
        logic [1:0] x [4];
        c = '{UCD_CMD_SET_RX_EXT, UCD_CMD_SET_TX_EXT, UCD_CMD_CLR_RX_EXT,
              UCD_CMD_CLR_TX_EXT};
        x = '{2'h2, 2'h3, 2'h1, 2'h0};
        for (int i = 0; i < 4; i++) begin
            cmd(c[i]);
            rd(UCD_STAT_OFF);
            chk({rx_ext, tx_ext}, {30'h0, x[i]});
            chk(r[UCD_ST_RXEXT_BIT +: 2], {30'h0, x[i][0], x[i][1]});
        end
    endtask
    task automatic t_errors();
        wr(UCD_CTRL_OFF, 32'h1);
        for (int k = 0; k < 3; k++) begin
            pulse(k);
            rd(UCD_STAT_OFF);
            chk(r[7:4], 4'h2 << k);
            cmd(UCD_CMD_RST_ERR);
            rd(UCD_STAT_OFF);
            chk(r[7:4], 4'h0);
        end
        wr(UCD_CTRL_OFF, 32'h0);
        for (int k = 0; k < 3; k++) begin
            head <= 3'h1 << k;
            rd(UCD_STAT_OFF);
            chk(r[7:5], 3'h1 << k);
        end
        head <= 3'h0;
        pulse(3);
        rd(UCD_STAT_OFF);
        chk(r[7:4], 4'h1);
        cmd(UCD_CMD_RST_ERR);
        rd(UCD_STAT_OFF);
        chk(r[7:4], 4'h0);
    endtask
    task automatic t_brkchg();
        pulse(4);
        rd(UCD_STAT_OFF);
        // Flag set, interrupt still masked
        chk({r[UCD_ST_BRKCHG_BIT], irq}, 32'h2);
        wr(UCD_IRQ_MASK_OFF, 32'h1 << UCD_IRQ_BRKCHG_BIT);
        repeat (2) @(posedge clk);
        chk({r[UCD_ST_BRKCHG_BIT], irq}, 32'h3);
        cmd(UCD_CMD_RST_BRK_CHG);
        wr(UCD_IRQ_STAT_OFF, 32'h1 << UCD_IRQ_BRKCHG_BIT);
        repeat (2) @(posedge clk);
        rd(UCD_STAT_OFF);
        chk({r[UCD_ST_BRKCHG_BIT], irq}, 32'h0);
    endtask
    task automatic t_break();
        tx_empty <= 1'b1;
        cmd(UCD_CMD_START_BRK);
        repeat (3 * BC) @(posedge clk);
        chk({serial, hold}, 32'h2);
        // Transmitter enabled before the break, as the host must
        wr(UCD_CTRL_OFF, 32'h2);
        tx_empty <= 1'b0;
        cmd(UCD_CMD_START_BRK);
        repeat (3 * BC) @(posedge clk);
        chk({serial, hold}, 32'h3);
        tx_empty <= 1'b1;
        wait_tx(1'b0);
        chk(serial, 32'h0);
        repeat (3 * BC) @(posedge clk);
        chk(serial, 32'h0);
        cmd(UCD_CMD_STOP_BRK);
        wait_tx(1'b1);
        chk(serial, 32'h1);
        tx_data <= 1'b0;
        repeat (BC - 2) @(posedge clk);
        chk(serial, 32'h1);
        wait_tx(1'b0);
        chk({serial, hold}, 32'h0);
        tx_data <= 1'b1;
        // Idle and empty transmitter: break within two bit periods
        cmd(UCD_CMD_START_BRK);
        wait_tx(1'b0);
        chk(serial, 32'h0);
        cmd(UCD_CMD_STOP_BRK);
        wait_tx(1'b1);
        chk(serial, 32'h1);
    endtask
    task automatic conclude();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        head = 3'h0;
        ev = 5'h0;
        tx_empty = 1'b0;
        tx_data = 1'b1;
        failures = 0;
        checked = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ext();
        t_errors();
        t_brkchg();
        t_break();
        conclude();
    end
    // Whole run is well under a thousand cycles
    initial begin
        #500000;
        failures++;
        conclude();
    end
endmodule
